// ### rtl/tmc_cfg.svh
// Offsets, reset values and thresholds of the transmit MIB counters
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

`define TMC_OFS_BCAST_OCTETS 8'hD8
`define TMC_OFS_CARRIER_LOSS 8'hF8
`define TMC_OFS_XS_COLL_ABORT 8'hFC

`define TMC_RST_OCTETS 32'h0000_0000
`define TMC_RST_EVENTS 16'h0000

`define TMC_TH_OCTETS 32'hC000_0000
`define TMC_TH_EVENTS 16'hC000

`define TMC_VLAN_OCTETS 32'h0000_0004

`define TMC_MASK_BCAST_OCTETS 0
`define TMC_MASK_CARRIER_LOSS 1
`define TMC_MASK_XS_COLL_ABORT 2

`endif

// ### rtl/tmc_pkg.sv
// Types shared by the transmit MIB counter block
package tmc_pkg;
  typedef logic [31:0] tmc_octets_t;
  typedef logic [15:0] tmc_events_t;
  typedef logic [7:0] tmc_offset_t;
endpackage : tmc_pkg

// ### rtl/tmc_tx_mib.sv
// Transmit MIB statistics counters: broadcast octets, carrier loss, aborts
//
// Behaviour
// [R1] The octet counter adds data and pad octets of good broadcast frames.
// [R2] The octet counter wraps from all ones to zero, never saturating.
// [R3] Octet counts include the four VLAN tag octets only when a tag is inserted.
// [R4] The octet counter reaching 0xC0000000 raises the statistics event.
// [R5] A counter counts only with the global enable 1 and its mask bit 0.
// [R6] The octet counter is a 32-bit full-word register, reset to zero.
// [R7] The carrier counter counts each carrier drop in a collision-free frame.
// [R8] Carrier is ignored until preamble and start delimiter have gone out.
// [R9] Carrier-loss counter is 16 bits and wraps from its maximum to zero.
// [R10] The carrier counter reaching 0xC000 raises the statistics event.
// [R11] Abort counter counts each frame given up after excessive collisions.
// [R12] Abort counter is 16 bits and wraps from its maximum to zero.
// [R13] Abort counter reaching 0xC000 raises the update-statistics event.
// [R14] Abort counter is read and written at offset 0xFC.
// [R15] A software write loads a counter; counting goes on from that value.
`timescale 1ns/1ps
`include "tmc_cfg.svh"

module tmc_tx_mib #(
  parameter int OCTET_W = 32,
  parameter int EVENT_W = 16,
  parameter int LEN_W = 16
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // Register port, full double word only
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [31:0] I_REG_WDATA,
  output logic [31:0] O_REG_RDATA,
  output logic O_REG_HIT,
  // Statistics control bits
  input wire logic I_STATS_GLOBAL_ENABLE,
  input wire logic [2:0] I_STATS_MASK,
  // Transmit path, same clock
  input wire logic I_TX_DONE_OK,
  input wire logic I_TX_BCAST,
  input wire logic [LEN_W-1:0] I_TX_OCTETS,
  input wire logic I_TX_TAG_INSERTED,
  input wire logic I_TX_ACTIVE,
  input wire logic I_TX_SFD_SENT,
  input wire logic I_TX_COLLISION,
  input wire logic I_TX_ABORT_XS_COLL,
  // Carrier sense pin from the PHY
  input wire logic I_CRS,
  // Update-statistics event towards the interrupt status register
  output logic O_STATS_THRESHOLD_IRQ
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Read mux and tag adder are built for these widths only
  if (OCTET_W != 32 || EVENT_W != 16 || LEN_W < 1 ||
      LEN_W > 31) begin : g_bad_width
    $error("tmc_tx_mib: unsupported width");
  end

  // ----------------------------------------------------------------
  // Carrier sense synchroniser
  // ----------------------------------------------------------------
  logic crs_meta_q, crs_meta_d;
  logic crs_sync_q, crs_sync_d;
  logic crs_prev_q, crs_prev_d;
  logic coll_seen_q, coll_seen_d;
  logic crs_drop;

  always_comb begin
    crs_meta_d = I_CRS;
    crs_sync_d = crs_meta_q;
    crs_prev_d = crs_sync_q;
    coll_seen_d = coll_seen_q;
    if (!I_TX_ACTIVE) begin
      coll_seen_d = 1'b0;
    end else if (I_TX_COLLISION) begin
      coll_seen_d = 1'b1;
    end
  end

  // Falling carrier after the start delimiter of a clean frame
  assign crs_drop = crs_prev_q && !crs_sync_q && I_TX_ACTIVE &&
    I_TX_SFD_SENT && !coll_seen_q && !I_TX_COLLISION; // [R7] [R8]

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      // Idle carrier level, so no false drop follows reset
      crs_meta_q <= 1'b1;
      crs_sync_q <= 1'b1;
      crs_prev_q <= 1'b1;
      coll_seen_q <= 1'b0;
    end else begin
      crs_meta_q <= crs_meta_d;
      crs_sync_q <= crs_sync_d;
      crs_prev_q <= crs_prev_d;
      coll_seen_q <= coll_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  tmc_pkg::tmc_octets_t bcast_octets_q, bcast_octets_d;
  tmc_pkg::tmc_events_t carrier_loss_q, carrier_loss_d;
  tmc_pkg::tmc_events_t xs_abort_q, xs_abort_d;
  tmc_pkg::tmc_octets_t frame_octets;
  logic en_oct, en_crs, en_abt;
  logic wr_oct, wr_crs, wr_abt;
  logic hit_oct, hit_crs, hit_abt;
  logic irq_d, irq_q;

  assign en_oct = I_STATS_GLOBAL_ENABLE &&
    !I_STATS_MASK[`TMC_MASK_BCAST_OCTETS]; // [R5]
  assign en_crs = I_STATS_GLOBAL_ENABLE &&
    !I_STATS_MASK[`TMC_MASK_CARRIER_LOSS]; // [R5]
  assign en_abt = I_STATS_GLOBAL_ENABLE &&
    !I_STATS_MASK[`TMC_MASK_XS_COLL_ABORT]; // [R5]

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign hit_oct = I_REG_ADDR == `TMC_OFS_BCAST_OCTETS;
  assign hit_crs = I_REG_ADDR == `TMC_OFS_CARRIER_LOSS;
  assign hit_abt = I_REG_ADDR == `TMC_OFS_XS_COLL_ABORT; // [R14]
  assign wr_oct = I_REG_WR && hit_oct;
  assign wr_crs = I_REG_WR && hit_crs;
  assign wr_abt = I_REG_WR && hit_abt;

  // Inserted tag is not in the length the DMA reports, so add it here
  assign frame_octets = 32'(I_TX_OCTETS) +
    (I_TX_TAG_INSERTED ? `TMC_VLAN_OCTETS : 32'h0000_0000); // [R3]

  always_comb begin
    bcast_octets_d = bcast_octets_q;
    carrier_loss_d = carrier_loss_q;
    xs_abort_d = xs_abort_q;
    irq_d = 1'b0;
    // Software load wins over a same-cycle count
    if (wr_oct) begin
      bcast_octets_d = I_REG_WDATA; // [R6] [R15]
    end else if (en_oct && I_TX_DONE_OK && I_TX_BCAST) begin
      bcast_octets_d = bcast_octets_q + frame_octets; // [R1] [R2]
      // Multi-octet steps can jump over the exact value, so test a crossing
      if (bcast_octets_q < `TMC_TH_OCTETS &&
          bcast_octets_d >= `TMC_TH_OCTETS) begin
        irq_d = 1'b1; // [R4]
      end
    end
    if (wr_crs) begin
      carrier_loss_d = I_REG_WDATA[15:0]; // [R15]
    end else if (en_crs && crs_drop) begin
      carrier_loss_d = carrier_loss_q + 16'h0001; // [R9]
      if (carrier_loss_d == `TMC_TH_EVENTS) begin
        irq_d = 1'b1; // [R10]
      end
    end
    if (wr_abt) begin
      xs_abort_d = I_REG_WDATA[15:0]; // [R15]
    end else if (en_abt && I_TX_ABORT_XS_COLL) begin
      xs_abort_d = xs_abort_q + 16'h0001; // [R11] [R12]
      if (xs_abort_d == `TMC_TH_EVENTS) begin
        irq_d = 1'b1; // [R13]
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      bcast_octets_q <= `TMC_RST_OCTETS; // [R6]
      carrier_loss_q <= `TMC_RST_EVENTS;
      xs_abort_q <= `TMC_RST_EVENTS;
      irq_q <= 1'b0;
    end else begin
      bcast_octets_q <= bcast_octets_d;
      carrier_loss_q <= carrier_loss_d;
      xs_abort_q <= xs_abort_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Update-statistics event
  // ----------------------------------------------------------------
  assign O_STATS_THRESHOLD_IRQ = irq_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_d, rdata_q;
  logic rhit_d, rhit_q;

  always_comb begin
    // Zero when idle, so several blocks can share one read path
    rdata_d = 32'h0000_0000;
    rhit_d = 1'b0;
    if (I_REG_RD) begin
      rhit_d = hit_oct || hit_crs || hit_abt;
      if (hit_oct) begin
        rdata_d = bcast_octets_q;
      end else if (hit_crs) begin
        rdata_d = {16'h0000, carrier_loss_q};
      end else if (hit_abt) begin
        rdata_d = {16'h0000, xs_abort_q}; // [R14]
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      rdata_q <= 32'h0000_0000;
      rhit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rhit_q <= rhit_d;
    end
  end

  assign O_REG_RDATA = rdata_q;
  assign O_REG_HIT = rhit_q;

endmodule : tmc_tx_mib

// ### verif/tmc_phy_model.sv
// Carrier sense pin of the PHY
`timescale 1ns/1ps
module tmc_phy_model (
  // Carrier drop request
  input wire logic i_drop,
  // Carrier pin
  output logic o_crs
);
  // Held high between drops, so no loss is seen
  assign o_crs = ~i_drop;
endmodule : tmc_phy_model

// ### verif/tmc_tx_mib_sva.sv
// Port checker of the transmit MIB counters
`timescale 1ns/1ps
module tmc_tx_mib_sva (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic O_REG_HIT,
  // Counting controls, events and the statistics event
  input wire logic I_STATS_GLOBAL_ENABLE,
  input wire logic [2:0] I_STATS_MASK,
  input wire logic I_TX_DONE_OK,
  input wire logic I_TX_ABORT_XS_COLL,
  input wire logic O_STATS_THRESHOLD_IRQ
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_unm; I_REG_RD && !(I_REG_ADDR inside {8'hD8, 8'hF8, 8'hFC})
    |=> !O_REG_HIT && O_REG_RDATA == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hit; I_REG_RD && I_REG_ADDR == 8'hFC |=> O_REG_HIT; endproperty
  a_hit: assert property (p_hit) else $error("abort read");
  property p_idl; !I_REG_RD |=> O_REG_RDATA == 32'h0; endproperty
  a_idl: assert property (p_idl) else $error("idle data");
  property p_off; !I_STATS_GLOBAL_ENABLE |=> !O_STATS_THRESHOLD_IRQ;
  endproperty
  a_off: assert property (p_off) else $error("irq when off");
  property p_msk; &I_STATS_MASK |=> !O_STATS_THRESHOLD_IRQ; endproperty
  a_msk: assert property (p_msk) else $error("irq when masked");
  property p_orw; I_REG_WR && I_REG_ADDR == 8'hD8 ##1 I_REG_RD && !I_REG_WR
    && !I_TX_DONE_OK && I_REG_ADDR == 8'hD8
    |=> O_REG_RDATA == $past(I_REG_WDATA, 2); endproperty
  a_orw: assert property (p_orw) else $error("octet load");
  property p_arw; I_REG_WR && I_REG_ADDR == 8'hFC ##1 I_REG_RD && !I_REG_WR
    && !I_TX_ABORT_XS_COLL && I_REG_ADDR == 8'hFC
    |=> O_REG_RDATA == ($past(I_REG_WDATA, 2) & 32'hFFFF); endproperty
  a_arw: assert property (p_arw) else $error("abort load");
  property p_thr; I_REG_WR && I_REG_ADDR == 8'hFC && I_REG_WDATA[15:0] ==
    16'hBFFF ##1 I_TX_ABORT_XS_COLL && !I_REG_WR && I_STATS_GLOBAL_ENABLE
    && !I_STATS_MASK[2] |=> O_STATS_THRESHOLD_IRQ; endproperty
  a_thr: assert property (p_thr) else $error("abort threshold");
endmodule : tmc_tx_mib_sva
bind tmc_tx_mib tmc_tx_mib_sva tmc_tx_mib_sva_i (
  .I_REF_CLK(I_REF_CLK),
  .I_RST_N(I_RST_N),
  .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WR(I_REG_WR),
  .I_REG_RD(I_REG_RD),
  .I_REG_WDATA(I_REG_WDATA),
  .O_REG_RDATA(O_REG_RDATA),
  .O_REG_HIT(O_REG_HIT),
  .I_STATS_GLOBAL_ENABLE(I_STATS_GLOBAL_ENABLE),
  .I_STATS_MASK(I_STATS_MASK),
  .I_TX_DONE_OK(I_TX_DONE_OK),
  .I_TX_ABORT_XS_COLL(I_TX_ABORT_XS_COLL),
  .O_STATS_THRESHOLD_IRQ(O_STATS_THRESHOLD_IRQ)
);

// ### verif/tb_tmc_tx_mib.sv
// Self-checking bench of the transmit MIB counters
`timescale 1ns/1ps
module tb_tmc_tx_mib;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, gen = 0, ok = 0, bc = 0, tag = 0;
  logic act = 0, sfd = 0, col = 0, abt = 0, drop = 0, crs, hit, irq;
  logic [7:0] adr = 8'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [2:0] msk = 3'h0;
  logic [15:0] len = 16'h0;
  int err_count = 0, n_compared = 0, irq_n = 0, n0;
  tmc_tx_mib tmc_tx_mib_i (.I_REF_CLK(clk), .I_RST_N(rst_n),
    .I_REG_ADDR(adr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wd),
    .O_REG_RDATA(rdat), .O_REG_HIT(hit), .I_STATS_GLOBAL_ENABLE(gen),
    .I_STATS_MASK(msk), .I_TX_DONE_OK(ok), .I_TX_BCAST(bc),
    .I_TX_OCTETS(len), .I_TX_TAG_INSERTED(tag), .I_TX_ACTIVE(act),
    .I_TX_SFD_SENT(sfd), .I_TX_COLLISION(col), .I_TX_ABORT_XS_COLL(abt),
    .I_CRS(crs), .O_STATS_THRESHOLD_IRQ(irq));
  tmc_phy_model tmc_phy_model_i (.i_drop(drop), .o_crs(crs));
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // Write, then optionally a read or an abort on the very next cycle
  task automatic wreg(logic [7:0] a, logic [31:0] d, logic r, logic x);
    @(posedge clk);
    {wr, adr, wd} <= {1'b1, a, d};
    @(posedge clk);
    {wr, rd, abt} <= {1'b0, r, x};
    @(posedge clk);
    {rd, abt} <= 2'h0;
  endtask : wreg
  task automatic rreg(logic [7:0] a, logic [31:0] e, string nm);
    @(posedge clk);
    {rd, adr} <= {1'b1, a};
    @(posedge clk);
    rd <= 0;
    #1 chk(nm, e, rdat);
  endtask : rreg
  task automatic frame(logic b, logic [15:0] l, logic t, logic x);
    @(posedge clk);
    {ok, bc, len, tag, abt} <= {~x, b, l, t, x};
    @(posedge clk);
    {ok, abt} <= 2'h0;
  endtask : frame
  // Drop before the delimiter, then one after it
  task automatic car(logic c);
    // One idle edge, so back-to-back calls are separate frames
    @(posedge clk);
    {act, col} <= {1'b1, c};
    for (int i = 0; i < 4; i++) begin
      {drop, sfd} <= {~i[0], i[1]};
      repeat (4) @(posedge clk);
    end
    {act, col, sfd} <= 3'h0;
  endtask : car
  task automatic t_oct();
    wreg(8'hD8, 32'h0000_1000, 1, 0);
    #1 chk("octet load", 32'h0000_1000, rdat);
    frame(1, 16'h003C, 1, 0);
    frame(0, 16'h0064, 0, 0);
    frame(1, 16'hFFFF, 0, 0);
    rreg(8'hD8, 32'h0000_1040 + 32'h0000_FFFF, "octets");
    wreg(8'hD8, 32'hFFFF_FFFC, 0, 0);
    frame(1, 16'h0005, 0, 0);
    rreg(8'hD8, 32'h0000_0001, "octet wrap");
    n0 = irq_n;
    wreg(8'hD8, 32'hBFFF_FFFC, 0, 0);
    frame(1, 16'h0000, 1, 0);
    repeat (2) @(posedge clk);
    #1 chk("octet irq", 32'(n0 + 1), 32'(irq_n));
  endtask : t_oct
  // Counts that would reach a threshold if the gating failed
  task automatic t_gate();
    n0 = irq_n;
    wreg(8'hD8, 32'hBFFF_FFFC, 0, 0);
    wreg(8'hFC, 32'h0000_BFFF, 0, 0);
    msk <= 3'h7;
    frame(1, 16'h0004, 0, 0);
    {msk, gen} <= 4'h0;
    frame(1, 16'h0004, 0, 1);
    gen <= 1'b1;
    rreg(8'hD8, 32'hBFFF_FFFC, "masked octets");
    rreg(8'hFC, 32'h0000_BFFF, "gated abort");
    chk("gated irq", 32'(n0), 32'(irq_n));
  endtask : t_gate
  task automatic t_car();
    n0 = irq_n;
    wreg(8'hF8, 32'h0000_BFFF, 0, 0);
    car(0);
    car(1);
    rreg(8'hF8, 32'h0000_C000, "carrier");
    chk("carrier irq", 32'(n0 + 1), 32'(irq_n));
    wreg(8'hF8, 32'h0000_FFFF, 0, 0);
    car(0);
    rreg(8'hF8, 32'h0000_0000, "carrier wrap");
  endtask : t_car
  task automatic t_abt();
    wreg(8'hFC, 32'h0000_FFFF, 0, 1);
    rreg(8'hFC, 32'h0000_0000, "abort wrap");
    n0 = irq_n;
    wreg(8'hFC, 32'h0000_BFFF, 0, 1);
    frame(0, 16'h0000, 0, 1);
    rreg(8'hFC, 32'h0000_C001, "aborts");
    chk("abort hit", 32'h0000_0001, 32'(hit));
    chk("abort irq", 32'(n0 + 1), 32'(irq_n));
    wreg(8'hFC, 32'hABCD_1234, 1, 0);
    #1 chk("abort load", 32'h0000_1234, rdat);
    rreg(8'hF0, 32'h0000_0000, "unmapped");
    chk("unmapped hit", 32'h0000_0000, 32'(hit));
  endtask : t_abt
  initial begin
    #1000000 err_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    {rst_n, gen} <= 2'h3;
    rreg(8'hD8, 32'h0000_0000, "reset");
    t_oct();
    t_gate();
    t_car();
    t_abt();
    summarize();
  end
endmodule : tb_tmc_tx_mib
